// File: rtl/rx_pkg.sv
// constants, field layout and carrier types of the serial receive path
// assumes an apb master on pclk and a 100 MHz system clock
// Functional notes
// - only the first stop bit is checked; stop-count selection never affects frame error.
// - overrun when buffer holds two, a frame waits in shift register, start detected.
// - overrun pending clears when the next frame completes; that frame's entry carries the flag.
// - parity error reads zero whenever parity checking is disabled.
// - upper parity-mode bit enables checking; lower bit picks odd or even parity.
// - parity result is stored in the buffer entry with data and stop status.
// - parity flag shows oldest unread character, valid until the data register read.
// - clearing enable stops reception at once and releases the receive pin.
// - disabling the receiver empties the buffer with all stored status.
// - line sampled at sixteen times baud, or eight times in double speed.
// - first low sample is one; samples 8-10 or 4-6 validate the start.
// - two or more high validation samples reject the start as noise.
// - bit phase resynchronises on every valid start bit.
// - sixteen or eight sample states per bit, sample numbered by state.
// - each bit is a majority of three centre samples, up to first stop.
// - stop bit voting zero sets frame error for that frame.
// - normal mode accepts a new edge right after last stop vote; double later.
// - first vote sample is 8 normal, 4 double; middle is 9 or 5.
// - error flags travel with their frame and advance on data register read.
package rx_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_FORMAT = 8'h0c;
	localparam logic [7:0] OFS_BAUD = 8'h10;

	// field positions
	localparam int STAT_U2X = 0;
	localparam int STAT_UPE = 2;
	localparam int STAT_DOR = 3;
	localparam int STAT_FE = 4;
	localparam int STAT_RXC = 7;
	localparam int CTRL_RECEIVER_ENABLE_BIT = 0;
	localparam int FMT_CSZ = 0;
	localparam int FMT_SBS = 2;
	localparam int FMT_PM = 4;

	// reset values
	localparam logic RST_RECEIVER_ENABLE_BIT = 1'b0;
	localparam logic RST_U2X = 1'b0;
	localparam logic [1:0] RST_CSZ = 2'h3;
	localparam logic RST_SBS = 1'b0;
	localparam logic [1:0] RST_PM = 2'h0;
	localparam logic [11:0] RST_BAUD = 12'h000;

	// sampling counts, minimum data bits and baud divisor width
	localparam logic [4:0] SAMP_NORMAL = 5'h10;
	localparam logic [4:0] SAMP_DOUBLE = 5'h08;
	localparam logic [4:0] SF_NORMAL = 5'h08;
	localparam logic [4:0] SF_DOUBLE = 5'h04;
	localparam logic [3:0] MIN_DATA_BITS = 4'h5;
	localparam int BAUD_W = 12;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_START = 4'b0010,
		ST_FRAME = 4'b0100,
		ST_TAIL = 4'b1000
	} rx_state_t;

	typedef struct packed {
		logic [7:0] data;
		logic fe;
		logic overrun_flag;
		logic parity_error_flag;
	} rx_entry_t;

	typedef struct packed {
		logic enable;
		logic double_speed;
		logic [1:0] char_size;
		logic stop_sel;
		logic [1:0] parity_mode;
		logic [BAUD_W-1:0] baud;
	} rx_cfg_t;

endpackage

// File: rtl/rx_pin_sync.sv
// three-stage synchroniser for the receive pin
// assumes the pin is asynchronous to pclk and idles high
`timescale 1ns/1ns
`default_nettype none
module rx_pin_sync (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pin and filtered level
	input wire logic pin,
	output logic level
);
	logic s1_q, s2_q, s3_q, lvl_q;
	logic lvl_d;

	// stage one feeds only stage two; a change counts once two and three agree
	always_comb begin
		lvl_d = lvl_q;
		if (s2_q == s3_q) begin
			lvl_d = s2_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			lvl_q <= 1'b1;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	assign level = lvl_q;
endmodule // rx_pin_sync
`default_nettype wire

// File: rtl/rx_tick_gen.sv
// oversampling tick: one pclk-wide pulse every divisor+1 cycles
// assumes the divisor is static while the receiver runs
`timescale 1ns/1ns
`default_nettype none
module rx_tick_gen #(
	parameter int W = 12
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic run,
	input wire logic [W-1:0] divisor,
	// tick out
	output logic tick
);
	logic [W-1:0] cnt_q, cnt_d;
	logic tick_q, tick_d;

	always_comb begin
		cnt_d = cnt_q;
		tick_d = 1'b0;
		if (!run) begin
			cnt_d = '0;
		end else if (cnt_q == '0) begin
			cnt_d = divisor;
			tick_d = 1'b1;
		end else begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule // rx_tick_gen
`default_nettype wire

// File: rtl/serial_rx.sv
// serial receive path: start detection, oversampled data recovery,
// two-entry receive buffer with per-frame error flags, apb register slave
// assumes a remote transmitter on the receive pin and one apb master
`timescale 1ns/1ns
`default_nettype none
module serial_rx #(
	parameter int AW = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial pin
	input wire logic serial_receive_pin,
	output logic pin_owned
);
	rx_pkg::rx_cfg_t cfg_q, cfg_d;
	rx_pkg::rx_state_t st_q, st_d;
	logic [4:0] samp_q, samp_d;
	logic [1:0] votes_q, votes_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] shift_q, shift_d;
	logic pbit_q, pbit_d;
	logic prev_q, prev_d;
	rx_pkg::rx_entry_t mem_q [2];
	rx_pkg::rx_entry_t mem_d [2];
	rx_pkg::rx_entry_t hold_q, hold_d;
	logic hold_v_q, hold_v_d;
	logic [1:0] cnt_q, cnt_d;
	logic rdp_q, rdp_d;
	logic dor_pend_q, dor_pend_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic pop_arm_q, pop_arm_d;
	logic own_q;

	logic rx_s, tick;
	logic [4:0] spb, sf, cur;
	logic [3:0] nb;
	logic pen, maj3;
	logic frame_done, new_start;
	rx_pkg::rx_entry_t frame_entry, head;
	logic access, done, pop, receive_complete_flag;
	logic [1:0] cnt_ap;
	logic rdp_ap, wr_idx;
	logic [AW-1:0] a_data, a_stat, a_ctrl, a_fmt, a_baud;
	logic hit;
	logic [31:0] rmux;

	rx_pin_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin(serial_receive_pin),
		.level(rx_s)
	);

	rx_tick_gen #(.W(rx_pkg::BAUD_W)) u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.run(cfg_q.enable),
		.divisor(cfg_q.baud),
		.tick(tick)
	);

	// ---- data recovery ----
	always_comb begin
		spb = cfg_q.double_speed ? rx_pkg::SAMP_DOUBLE : rx_pkg::SAMP_NORMAL;
		sf = cfg_q.double_speed ? rx_pkg::SF_DOUBLE : rx_pkg::SF_NORMAL;
		cur = (samp_q >= spb) ? 5'h01 : samp_q + 5'h01;
		nb = rx_pkg::MIN_DATA_BITS + {2'h0, cfg_q.char_size};
		pen = cfg_q.parity_mode[1];
		maj3 = (votes_q[1] & votes_q[0]) | (votes_q[1] & rx_s) | (votes_q[0] & rx_s);
		st_d = st_q;
		samp_d = samp_q;
		votes_d = votes_q;
		bit_d = bit_q;
		shift_d = shift_q;
		pbit_d = pbit_q;
		prev_d = prev_q;
		frame_done = 1'b0;
		new_start = 1'b0;
		frame_entry = '0;
		frame_entry.data = shift_q;
		frame_entry.fe = ~maj3;
		frame_entry.parity_error_flag = pen & (^shift_q ^ pbit_q ^ cfg_q.parity_mode[0]);
		frame_entry.overrun_flag = dor_pend_q;
		if (!cfg_q.enable) begin
			// frame in progress is simply dropped
			st_d = rx_pkg::ST_IDLE;
			prev_d = 1'b1;
			samp_d = '0;
		end else if (tick) begin
			samp_d = cur;
			if (cur == sf || cur == sf + 5'h01) begin
				votes_d = {votes_q[0], rx_s};
			end
			case (st_q)
				rx_pkg::ST_IDLE: begin
					prev_d = rx_s;
					if (prev_q && !rx_s) begin
						st_d = rx_pkg::ST_START;
						samp_d = 5'h01;
						new_start = 1'b1;
					end
				end
				rx_pkg::ST_START: begin
					if (cur == sf + 5'h02) begin
						if (maj3) begin
							// noise spike: hunt for the next falling edge
							st_d = rx_pkg::ST_IDLE;
							prev_d = rx_s;
						end else begin
							st_d = rx_pkg::ST_FRAME;
							bit_d = '0;
							shift_d = '0;
							pbit_d = 1'b0;
						end
					end
				end
				rx_pkg::ST_FRAME: begin
					if (cur == sf + 5'h02) begin
						if (bit_q < nb) begin
							shift_d[bit_q[2:0]] = maj3;
							bit_d = bit_q + 4'h1;
						end else if (pen && bit_q == nb) begin
							pbit_d = maj3;
							bit_d = bit_q + 4'h1;
						end else begin
							// first stop bit ends the frame; later stop bits are just idle line
							frame_done = 1'b1;
							prev_d = maj3;
							st_d = cfg_q.double_speed ? rx_pkg::ST_TAIL : rx_pkg::ST_IDLE;
						end
					end
				end
				rx_pkg::ST_TAIL: begin
					// double speed holds off one sample before a new edge is accepted
					st_d = rx_pkg::ST_IDLE;
				end
				default: begin
					st_d = rx_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= rx_pkg::ST_IDLE;
			samp_q <= '0;
			votes_q <= '0;
			bit_q <= '0;
			shift_q <= '0;
			pbit_q <= 1'b0;
			prev_q <= 1'b1;
		end else begin
			st_q <= st_d;
			samp_q <= samp_d;
			votes_q <= votes_d;
			bit_q <= bit_d;
			shift_q <= shift_d;
			pbit_q <= pbit_d;
			prev_q <= prev_d;
		end
	end

	// ---- apb decode ----
	always_comb begin
		a_data = AW'(rx_pkg::OFS_DATA);
		a_stat = AW'(rx_pkg::OFS_STATUS);
		a_ctrl = AW'(rx_pkg::OFS_CTRL);
		a_fmt = AW'(rx_pkg::OFS_FORMAT);
		a_baud = AW'(rx_pkg::OFS_BAUD);
		hit = (paddr == a_data) || (paddr == a_stat) || (paddr == a_ctrl) ||
			(paddr == a_fmt) || (paddr == a_baud);
		access = psel & penable;
		done = access & pready_q;
		// pop only what the captured read data showed; a frame landing in the wait state stays unread
		pop = done & ~pwrite & (paddr == a_data) & pop_arm_q & (cnt_q != 2'h0);
	end

	// ---- receive buffer ----
	always_comb begin
		head = mem_q[rdp_q];
		receive_complete_flag = (cnt_q != 2'h0);
		rdp_ap = rdp_q ^ pop;
		cnt_ap = cnt_q - {1'b0, pop};
		wr_idx = rdp_ap ^ cnt_ap[0];
		mem_d = mem_q;
		hold_d = hold_q;
		hold_v_d = hold_v_q;
		dor_pend_d = dor_pend_q;
		cnt_d = cnt_ap;
		rdp_d = rdp_ap;
		if (!cfg_q.enable) begin
			cnt_d = '0;
			rdp_d = 1'b0;
			hold_v_d = 1'b0;
			dor_pend_d = 1'b0;
		end else begin
			if (hold_v_q && cnt_ap != 2'h2) begin
				mem_d[wr_idx] = hold_q;
				cnt_d = cnt_ap + 2'h1;
				hold_v_d = 1'b0;
			end
			if (new_start && hold_v_q && cnt_ap == 2'h2) begin
				// the waiting character is overwritten by the new frame
				hold_v_d = 1'b0;
				dor_pend_d = 1'b1;
			end
			if (frame_done) begin
				hold_d = frame_entry;
				hold_v_d = 1'b1;
				dor_pend_d = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			hold_q <= '0;
			hold_v_q <= 1'b0;
			cnt_q <= '0;
			rdp_q <= 1'b0;
			dor_pend_q <= 1'b0;
		end else begin
			mem_q <= mem_d;
			hold_q <= hold_d;
			hold_v_q <= hold_v_d;
			cnt_q <= cnt_d;
			rdp_q <= rdp_d;
			dor_pend_q <= dor_pend_d;
		end
	end

	// ---- registers and read path ----
	always_comb begin
		rmux = '0;
		if (paddr == a_data) begin
			rmux[7:0] = receive_complete_flag ? head.data : 8'h00;
		end else if (paddr == a_stat) begin
			rmux[rx_pkg::STAT_U2X] = cfg_q.double_speed;
			rmux[rx_pkg::STAT_UPE] = receive_complete_flag & head.parity_error_flag & cfg_q.parity_mode[1];
			rmux[rx_pkg::STAT_DOR] = receive_complete_flag & head.overrun_flag;
			rmux[rx_pkg::STAT_FE] = receive_complete_flag & head.fe;
			rmux[rx_pkg::STAT_RXC] = receive_complete_flag;
		end else if (paddr == a_ctrl) begin
			rmux[rx_pkg::CTRL_RECEIVER_ENABLE_BIT] = cfg_q.enable;
		end else if (paddr == a_fmt) begin
			rmux[rx_pkg::FMT_CSZ +: 2] = cfg_q.char_size;
			rmux[rx_pkg::FMT_SBS] = cfg_q.stop_sel;
			rmux[rx_pkg::FMT_PM +: 2] = cfg_q.parity_mode;
		end else if (paddr == a_baud) begin
			rmux[rx_pkg::BAUD_W-1:0] = cfg_q.baud;
		end
		// one wait state so that read data comes from a flop
		pready_d = access & ~pready_q;
		prdata_d = prdata_q;
		// error stands only beside pready, so it never seems to belong to the next transfer
		pslverr_d = 1'b0;
		pop_arm_d = pop_arm_q;
		if (access && !pready_q) begin
			prdata_d = pwrite ? 32'h0000_0000 : rmux;
			pslverr_d = ~hit;
			pop_arm_d = receive_complete_flag;
		end
		cfg_d = cfg_q;
		if (done && pwrite) begin
			if (paddr == a_stat) begin
				// flag positions are read-only; writing them has no effect
				cfg_d.double_speed = pwdata[rx_pkg::STAT_U2X];
			end else if (paddr == a_ctrl) begin
				cfg_d.enable = pwdata[rx_pkg::CTRL_RECEIVER_ENABLE_BIT];
			end else if (paddr == a_fmt) begin
				cfg_d.char_size = pwdata[rx_pkg::FMT_CSZ +: 2];
				cfg_d.stop_sel = pwdata[rx_pkg::FMT_SBS];
				cfg_d.parity_mode = pwdata[rx_pkg::FMT_PM +: 2];
			end else if (paddr == a_baud) begin
				cfg_d.baud = pwdata[rx_pkg::BAUD_W-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q.enable <= rx_pkg::RST_RECEIVER_ENABLE_BIT;
			cfg_q.double_speed <= rx_pkg::RST_U2X;
			cfg_q.char_size <= rx_pkg::RST_CSZ;
			cfg_q.stop_sel <= rx_pkg::RST_SBS;
			cfg_q.parity_mode <= rx_pkg::RST_PM;
			cfg_q.baud <= rx_pkg::RST_BAUD;
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			pop_arm_q <= 1'b0;
			own_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			pop_arm_q <= pop_arm_d;
			own_q <= cfg_d.enable;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign pin_owned = own_q;
endmodule // serial_rx
`default_nettype wire

// File: bench/serial_rx_asserts.sv
// concurrent checks on the serial_rx ports: apb timing, pin ownership, flag reads
// assumes an apb master that keeps setup before access and holds its request
`timescale 1ns/1ns
`default_nettype none
module serial_rx_asserts #(
	parameter int AW = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pin ownership
	input wire logic pin_owned
);
	logic pm_on_q, pm_on_d, wr_done, rd_done, rd_stat, mapped;
	assign wr_done = pready && psel && penable && pwrite;
	assign rd_done = pready && psel && penable && !pwrite;
	assign rd_stat = rd_done && paddr == AW'(rx_pkg::OFS_STATUS);
	// offsets 0x00..0x10 are word indices 0..4
	assign mapped = paddr[1:0] == 2'h0 && paddr[AW-1:2] < (AW-2)'(5);
	// parity enable as software last set it; a read sees the current setting
	always_comb begin
		pm_on_d = pm_on_q;
		if (wr_done && paddr == AW'(rx_pkg::OFS_FORMAT)) begin
			pm_on_d = pwdata[rx_pkg::FMT_PM + 1];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pm_on_q <= 1'b0;
		end else begin
			pm_on_q <= pm_on_d;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_one_wait_state: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("pready not after exactly one wait state");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_unmapped: assert property (pslverr |-> pready && !mapped)
		else $error("pslverr on a mapped access");
	a_unmapped_refused: assert property (pready && psel && !mapped |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_pin_release: assert property (wr_done && paddr == AW'(rx_pkg::OFS_CTRL) && !pwdata[0] |=> !pin_owned)
		else $error("pin still owned after disable");
	a_pin_take: assert property (wr_done && paddr == AW'(rx_pkg::OFS_CTRL) && pwdata[0] |=> pin_owned)
		else $error("pin not owned after enable");
	a_pin_steady: assert property ($changed(pin_owned) |-> $past(wr_done))
		else $error("pin ownership changed without a write");
	a_parity_masked: assert property (rd_stat && !pm_on_q |-> !prdata[rx_pkg::STAT_UPE])
		else $error("parity flag set while checking off");
	a_flush_status: assert property (rd_stat && !pin_owned |-> prdata[31:2] == 30'h0)
		else $error("flags or data pending while disabled");
	a_flush_data: assert property (rd_done && paddr == AW'(rx_pkg::OFS_DATA) && !pin_owned |-> prdata == 32'h0)
		else $error("data readable while disabled");
	c_received: cover property (rd_stat && prdata[rx_pkg::STAT_RXC]);
	c_parity: cover property (rd_stat && prdata[rx_pkg::STAT_UPE]);
	c_overrun: cover property (rd_stat && prdata[rx_pkg::STAT_DOR]);
	c_refused: cover property (pslverr);
endmodule // serial_rx_asserts
bind serial_rx serial_rx_asserts #(.AW(AW)) serial_rx_asserts_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .pin_owned(pin_owned));
`default_nettype wire

// File: bench/serial_tx_model.sv
// remote transmitter driving the receive line, one pclk per oversample tick
// assumes baud divisor 0 in the receiver; line idles high between frames
`timescale 1ns/1ns
`default_nettype none
module serial_tx_model (
	// clock
	input wire logic pclk,
	// serial line
	output logic line
);
	initial line = 1'b1;
	task automatic bit_out(input bit v, input int spb);
		line <= v;
		repeat (spb) @(posedge pclk);
	endtask
	// bad and stp let a scenario break parity or stop on purpose
	task automatic send(input bit [7:0] d, input bit pe, input bit po, input bit bad, input bit stp, input int spb);
		@(posedge pclk);
		bit_out(1'b0, spb);
		for (int i = 0; i < 8; i++) begin
			bit_out(d[i], spb);
		end
		if (pe) begin
			bit_out((^d) ^ po ^ bad, spb);
		end
		bit_out(stp, spb);
		line <= 1'b1;
	endtask
	// low spike far shorter than the start validation window
	task automatic glitch(input int n);
		@(posedge pclk);
		line <= 1'b0;
		repeat (n) @(posedge pclk);
		line <= 1'b1;
	endtask
endmodule // serial_tx_model
`default_nettype wire

// File: bench/serial_rx_tb.sv
// self-checking bench for serial_rx: apb register tasks and framed line stimulus
// assumes serial_tx_model on the receive pin and baud divisor 0
`timescale 1ns/1ns
`default_nettype none
module serial_rx_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin_owned, rx_line, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	int err_total, comparisons;
	serial_rx serial_rx_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_receive_pin(rx_line), .pin_owned(pin_owned));
	serial_tx_model serial_tx_model_inst (.pclk(pclk), .line(rx_line));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) err_total++;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic y;
		xfer(1'b1, a, d, x, y);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		logic y;
		xfer(1'b0, a, 32'h0, x, y);
		chk(x, exp);
	endtask
	task automatic st(input logic [31:0] exp);
		rd(rx_pkg::OFS_STATUS, exp);
	endtask
	task automatic dt(input logic [31:0] exp);
		rd(rx_pkg::OFS_DATA, exp);
	endtask
	// the stop vote lands a few cycles before the line's stop bit ends, or just after it in double speed
	task automatic frame(input bit [7:0] d, input bit pe, input bit po, input bit bad, input bit stp, input int spb);
		serial_tx_model_inst.send(d, pe, po, bad, stp, spb);
		repeat (12) @(posedge pclk);
	endtask
	task automatic print_verdict;
		$display("err_total=%0d comparisons=%0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge pclk);
		err_total++;
		print_verdict;
	end
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		presetn = 1'b0;
		err_total = 0;
		comparisons = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		st(32'h0);
		rd(rx_pkg::OFS_CTRL, 32'h0);
		rd(rx_pkg::OFS_FORMAT, 32'h3);
		rd(rx_pkg::OFS_BAUD, 32'h0);
		xfer(1'b0, 8'h14, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		wr(rx_pkg::OFS_CTRL, 32'h1);
		frame(8'ha5, 0, 0, 0, 1, 16);
		st(32'h80);
		dt(32'ha5);
		serial_tx_model_inst.glitch(3);
		repeat (40) @(posedge pclk);
		st(32'h0);
		frame(8'h3c, 0, 0, 0, 1, 16);
		dt(32'h3c);
		wr(rx_pkg::OFS_FORMAT, 32'h7);
		frame(8'h5a, 0, 0, 0, 0, 16);
		st(32'h90);
		dt(32'h5a);
		serial_tx_model_inst.send(8'h81, 0, 0, 0, 1, 16);
		frame(8'h18, 0, 0, 0, 1, 16);
		st(32'h80);
		dt(32'h81);
		st(32'h80);
		dt(32'h18);
		for (int m = 0; m < 2; m++) begin
			wr(rx_pkg::OFS_FORMAT, {26'h0, 1'b1, m[0], 4'h3});
			serial_tx_model_inst.send(8'h71, 1, m[0], 0, 1, 16);
			frame(8'h72, 1, m[0], 1, 1, 16);
			st(32'h80);
			dt(32'h71);
			st(32'h84);
			dt(32'h72);
		end
		frame(8'h6e, 1, 1, 1, 1, 16);
		wr(rx_pkg::OFS_FORMAT, 32'h3);
		st(32'h80);
		// software flush: read data while receive-complete stays set
		xfer(1'b0, rx_pkg::OFS_STATUS, 32'h0, r, e);
		for (int n = 0; n < 4 && r[7] === 1'b1; n++) begin
			xfer(1'b0, rx_pkg::OFS_DATA, 32'h0, r, e);
			xfer(1'b0, rx_pkg::OFS_STATUS, 32'h0, r, e);
		end
		chk(r, 32'h0);
		for (int k = 1; k < 4; k++) begin
			serial_tx_model_inst.send(k[7:0], 0, 0, 0, 1, 16);
		end
		frame(8'h04, 0, 0, 0, 1, 16);
		st(32'h80);
		dt(32'h01);
		st(32'h80);
		dt(32'h02);
		st(32'h88);
		dt(32'h04);
		frame(8'h05, 0, 0, 0, 1, 16);
		st(32'h80);
		dt(32'h05);
		frame(8'h01, 0, 0, 0, 1, 16);
		wr(rx_pkg::OFS_FORMAT, 32'h23);
		st(32'h80);
		dt(32'h01);
		// seven data bits: the line's bit 7 is taken as the stop bit
		wr(rx_pkg::OFS_FORMAT, 32'h2);
		frame(8'hd5, 0, 0, 0, 1, 16);
		dt(32'h55);
		wr(rx_pkg::OFS_FORMAT, 32'h3);
		wr(rx_pkg::OFS_STATUS, 32'h1);
		frame(8'hc3, 0, 0, 0, 1, 8);
		st(32'h81);
		dt(32'hc3);
		serial_tx_model_inst.send(8'h11, 0, 0, 0, 1, 8);
		serial_tx_model_inst.send(8'h22, 0, 0, 0, 1, 8);
		fork
			frame(8'h33, 0, 0, 0, 1, 8);
			begin
				repeat (20) @(posedge pclk);
				dt(32'h11);
				st(32'h81);
				wr(rx_pkg::OFS_CTRL, 32'h0);
			end
		join
		st(32'h1);
		wr(rx_pkg::OFS_CTRL, 32'h1);
		st(32'h1);
		dt(32'h0);
		print_verdict;
	end
endmodule // serial_rx_tb
`default_nettype wire
